// *** hdl/csel_pkg.sv ***
// package: offsets, field positions, codes and types for clock source selection
package csel_pkg;
  // register offsets on the register port
  localparam logic [7:0] CSEL_OFS_PLL_DSP = 8'h0d; // pll_and_dsp_clock_source
  localparam logic [7:0] CSEL_OFS_DAC_OSR = 8'h0e; // dac_and_osr_clock_source
  localparam logic [7:0] CSEL_OFS_NCP = 8'h0f; // charge_pump_clock_source
  localparam logic [7:0] CSEL_OFS_ROUTE_A = 8'h10; // pin_clock_route_dsp_dac
  localparam logic [7:0] CSEL_OFS_ROUTE_B = 8'h11; // oversample / charge pump routes
  localparam logic [7:0] CSEL_OFS_ROUTE_C = 8'h12; // pll reference route
  // field positions (lsb of each 3-bit field)
  localparam int CSEL_LO_FIELD = 0; // bits 2-0
  localparam int CSEL_HI_FIELD = 4; // bits 6-4
  localparam int CSEL_FW = 3; // field width
  // value of every field after reset
  localparam logic [2:0] CSEL_FIELD_RST = 3'h0;
  // pin route code that selects the serial output pin
  localparam logic [2:0] CSEL_ROUTE_PIN = 3'h5;
  // number of selectable clock channels
  localparam int CSEL_NCH = 5;
  localparam int CSEL_CH_PLL = 0;
  localparam int CSEL_CH_DSP = 1;
  localparam int CSEL_CH_DAC = 2;
  localparam int CSEL_CH_OSR = 3;
  localparam int CSEL_CH_NCP = 4;

  // candidate clocks, sampled as levels on mclk
  typedef struct packed {
    logic pll_clk; // pll output
    logic internal_oscillator; // on-chip oscillator
    logic master_clk_pin; // master clock pin
    logic bit_clk; // serial bit clock
    logic serial_out_pin; // serial data output pin used as clock
  } csel_src_t;

  // selected pll reference and divider inputs
  typedef struct packed {
    logic pll_ref;
    logic dsp_div;
    logic dac_div;
    logic osr_div;
    logic ncp_div;
  } csel_clk_out_t;

  // switch-over sequencer states
  typedef enum logic [0:0] {CSEL_SW_RUN, CSEL_SW_ARM} csel_sw_t;
endpackage

// *** hdl/csel_switch.sv ***
// runt-free source switch for one clock channel
`timescale 1ns/1ps
module csel_switch (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // candidates indexed by code, unused codes tied low
  input wire logic [7:0] src,
  input wire logic [2:0] sel,
  // switched clock level
  output logic clk_out
);
  import csel_pkg::*;

  csel_sw_t state_q; // run or waiting for new source low
  logic [2:0] cur_q; // code now passed through
  logic out_q; // registered output level
  wire logic cur_lvl = src[cur_q]; // level of current source
  wire logic new_lvl = src[sel]; // level of requested source
  wire logic want_switch = (sel != cur_q); // new code pending

  // park low once current is low, take the new code while parked, resume only while it is low
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= CSEL_SW_RUN;
      cur_q <= CSEL_FIELD_RST;
      out_q <= 1'b0;
    end else begin
      unique case (state_q)
        CSEL_SW_RUN: begin
          if (want_switch && !cur_lvl) begin // low phase: safe cut [RQ14]
            state_q <= CSEL_SW_ARM;
            out_q <= 1'b0;
          end else begin
            out_q <= cur_lvl;
          end
        end
        CSEL_SW_ARM: begin
          out_q <= 1'b0; // held static while parked [RQ14]
          cur_q <= sel;
          if (!new_lvl) begin // resume only on a low level [RQ14]
            state_q <= CSEL_SW_RUN;
          end
        end
      endcase
    end
  end

  assign clk_out = out_q;
endmodule

// *** hdl/csel_top.sv ***
// clock source selection registers and muxes for pll and divider inputs
`timescale 1ns/1ps
// What this block does
// RQ1 - pll reference field at 0x0D bits 6-4
// RQ2 - auto mode overrides software pll reference choice
// RQ3 - undefined pll reference codes mute the reference
// RQ4 - dsp divider source field 0x0D bits 2-0
// RQ5 - master clock code auto-picks pll/pin or oscillator
// RQ6 - dac divider source field 0x0E bits 6-4
// RQ7 - oversample divider source field 0x0E bits 2-0
// RQ8 - charge pump divider source field 0x0F
// RQ9 - dsp pin route at 0x10 bits 6-4
// RQ10 - dac pin route at 0x10 bits 2-0
// RQ11 - oversample/charge pump pin routes at 0x11
// RQ12 - pll reference pin route at 0x12
// RQ13 - all fields reset to zero
// RQ14 - muted clocks static, switching without runt pulses
module csel_top (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // automatic clock configuration
  input wire logic auto_clock_mode,
  input wire logic [2:0] auto_pll_ref_select,
  input wire logic auto_master_use_oscillator,
  input wire logic auto_master_use_pll,
  // candidate clocks
  input wire csel_pkg::csel_src_t clk_src,
  // selected clocks
  output csel_pkg::csel_clk_out_t clk_sel
);
  import csel_pkg::*;

  // divider and pll reference source codes
  logic [2:0] pll_ref_select_q; // pll reference code
  logic [2:0] dsp_divider_source_q; // dsp divider code
  logic [2:0] dac_divider_source_q; // dac divider code
  logic [2:0] oversample_divider_source_q; // oversample divider code
  logic [2:0] charge_pump_divider_source_q; // charge pump divider code
  // serial output pin route codes
  logic [2:0] dsp_pin_clock_route_q; // dsp route
  logic [2:0] dac_pin_clock_route_q; // dac route
  logic [2:0] oversample_pin_clock_route_q; // oversample route
  logic [2:0] charge_pump_pin_clock_route_q; // charge pump route
  logic [2:0] pll_ref_pin_route_q; // pll reference route
  // read side
  logic [7:0] rdata_q; // registered read data

  // write decode
  wire logic wr_pll_dsp = reg_wr && (reg_addr == CSEL_OFS_PLL_DSP);
  wire logic wr_dac_osr = reg_wr && (reg_addr == CSEL_OFS_DAC_OSR);
  wire logic wr_ncp = reg_wr && (reg_addr == CSEL_OFS_NCP);
  wire logic wr_route_a = reg_wr && (reg_addr == CSEL_OFS_ROUTE_A);
  wire logic wr_route_b = reg_wr && (reg_addr == CSEL_OFS_ROUTE_B);
  wire logic wr_route_c = reg_wr && (reg_addr == CSEL_OFS_ROUTE_C);
  // write data split into the two field slots
  wire logic [2:0] wf_hi = reg_wdata[CSEL_HI_FIELD +: CSEL_FW]; // bits 6-4
  wire logic [2:0] wf_lo = reg_wdata[CSEL_LO_FIELD +: CSEL_FW]; // bits 2-0

  // 0x0d fields: pll reference and dsp divider codes
  always_ff @(posedge mclk) begin
    if (reset) begin
      pll_ref_select_q <= CSEL_FIELD_RST; // [RQ13]
      dsp_divider_source_q <= CSEL_FIELD_RST; // [RQ13]
    end else if (wr_pll_dsp) begin
      pll_ref_select_q <= wf_hi; // [RQ1]
      dsp_divider_source_q <= wf_lo; // [RQ4]
    end
  end

  // 0x0e fields: dac and oversample divider codes
  always_ff @(posedge mclk) begin
    if (reset) begin
      dac_divider_source_q <= CSEL_FIELD_RST; // [RQ13]
      oversample_divider_source_q <= CSEL_FIELD_RST; // [RQ13]
    end else if (wr_dac_osr) begin
      dac_divider_source_q <= wf_hi; // [RQ6]
      oversample_divider_source_q <= wf_lo; // [RQ7]
    end
  end

  // 0x0f field: charge pump divider code
  always_ff @(posedge mclk) begin
    if (reset) begin
      charge_pump_divider_source_q <= CSEL_FIELD_RST; // [RQ13]
    end else if (wr_ncp) begin
      charge_pump_divider_source_q <= wf_lo; // [RQ8]
    end
  end

  // 0x10 fields: dsp and dac pin routes
  always_ff @(posedge mclk) begin
    if (reset) begin
      dsp_pin_clock_route_q <= CSEL_FIELD_RST; // [RQ13]
      dac_pin_clock_route_q <= CSEL_FIELD_RST; // [RQ13]
    end else if (wr_route_a) begin
      dsp_pin_clock_route_q <= wf_hi; // [RQ9]
      dac_pin_clock_route_q <= wf_lo; // [RQ10]
    end
  end

  // 0x11 fields: charge pump and oversample pin routes
  always_ff @(posedge mclk) begin
    if (reset) begin
      charge_pump_pin_clock_route_q <= CSEL_FIELD_RST; // [RQ13]
      oversample_pin_clock_route_q <= CSEL_FIELD_RST; // [RQ13]
    end else if (wr_route_b) begin
      charge_pump_pin_clock_route_q <= wf_hi; // [RQ11]
      oversample_pin_clock_route_q <= wf_lo; // [RQ11]
    end
  end

  // 0x12 field: pll reference pin route
  always_ff @(posedge mclk) begin
    if (reset) begin
      pll_ref_pin_route_q <= CSEL_FIELD_RST; // [RQ13]
    end else if (wr_route_c) begin
      pll_ref_pin_route_q <= wf_lo; // [RQ12]
    end
  end

  // register images as software reads them, reserved bits zero
  wire logic [7:0] img_pll_dsp = {1'b0, pll_ref_select_q, 1'b0, dsp_divider_source_q};
  wire logic [7:0] img_dac_osr = {1'b0, dac_divider_source_q, 1'b0,
                                  oversample_divider_source_q};
  wire logic [7:0] img_ncp = {5'h00, charge_pump_divider_source_q};
  wire logic [7:0] img_route_a = {1'b0, dsp_pin_clock_route_q, 1'b0,
                                  dac_pin_clock_route_q};
  wire logic [7:0] img_route_b = {1'b0, charge_pump_pin_clock_route_q, 1'b0,
                                  oversample_pin_clock_route_q};
  wire logic [7:0] img_route_c = {5'h00, pll_ref_pin_route_q};

  // read selection, unmapped offsets read zero
  wire logic [7:0] rd_mux = (reg_addr == CSEL_OFS_PLL_DSP) ? img_pll_dsp :
                            (reg_addr == CSEL_OFS_DAC_OSR) ? img_dac_osr :
                            (reg_addr == CSEL_OFS_NCP) ? img_ncp :
                            (reg_addr == CSEL_OFS_ROUTE_A) ? img_route_a :
                            (reg_addr == CSEL_OFS_ROUTE_B) ? img_route_b :
                            (reg_addr == CSEL_OFS_ROUTE_C) ? img_route_c : 8'h00;

  // read data captured one cycle after reg_rd
  // holds between reads so software sees a steady value
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      rdata_q <= rd_mux;
    end
  end
  assign reg_rdata = rdata_q;

  // pin routes: only the serial output code passes a clock, others mute
  wire logic gp_dsp = (dsp_pin_clock_route_q == CSEL_ROUTE_PIN)
                      & clk_src.serial_out_pin; // [RQ9]
  wire logic gp_dac = (dac_pin_clock_route_q == CSEL_ROUTE_PIN)
                      & clk_src.serial_out_pin; // [RQ10]
  wire logic gp_osr = (oversample_pin_clock_route_q == CSEL_ROUTE_PIN)
                      & clk_src.serial_out_pin; // [RQ11]
  wire logic gp_ncp = (charge_pump_pin_clock_route_q == CSEL_ROUTE_PIN)
                      & clk_src.serial_out_pin; // [RQ11]
  wire logic gp_ref = (pll_ref_pin_route_q == CSEL_ROUTE_PIN)
                      & clk_src.serial_out_pin; // [RQ12]

  // auto master clock: oscillator when selected, else pll or pin path
  wire logic pll_or_pin = auto_master_use_pll ? clk_src.pll_clk
                                              : clk_src.master_clk_pin;
  wire logic master_clk = auto_master_use_oscillator ? clk_src.internal_oscillator
                                                     : pll_or_pin; // [RQ5]

  // pll reference code, auto mode overrides software choice
  wire logic [2:0] ref_code = auto_clock_mode ? auto_pll_ref_select
                                              : pll_ref_select_q; // [RQ2]

  // candidate vectors by code, upper codes tied low so they mute
  logic [7:0] src_vec [CSEL_NCH];
  logic [2:0] sel_vec [CSEL_NCH];
  logic [CSEL_NCH-1:0] out_vec;

  // pll reference: mclk pin, bit clock, oscillator, pin route [RQ1]
  assign src_vec[CSEL_CH_PLL] = {4'h0, gp_ref, clk_src.internal_oscillator,
                                 clk_src.bit_clk, clk_src.master_clk_pin}; // [RQ3]
  // dsp: master, pll, oscillator, mclk pin, bit clock, pin route [RQ4]
  assign src_vec[CSEL_CH_DSP] = {2'h0, gp_dsp, clk_src.bit_clk, clk_src.master_clk_pin,
                                 clk_src.internal_oscillator, clk_src.pll_clk, master_clk};
  // dac: same code set as dsp [RQ6]
  assign src_vec[CSEL_CH_DAC] = {2'h0, gp_dac, clk_src.bit_clk, clk_src.master_clk_pin,
                                 clk_src.internal_oscillator, clk_src.pll_clk, master_clk};
  // oversample: dac clock first, then the dsp set shifted [RQ7]
  // the dac clock here is a flop output, so there is no loop
  assign src_vec[CSEL_CH_OSR] = {1'b0, gp_osr, clk_src.bit_clk, clk_src.master_clk_pin,
                                 clk_src.internal_oscillator, clk_src.pll_clk, master_clk,
                                 out_vec[CSEL_CH_DAC]};
  // charge pump: same seven codes as oversample [RQ8]
  assign src_vec[CSEL_CH_NCP] = {1'b0, gp_ncp, clk_src.bit_clk, clk_src.master_clk_pin,
                                 clk_src.internal_oscillator, clk_src.pll_clk, master_clk,
                                 out_vec[CSEL_CH_DAC]};
  // selection code per channel
  assign sel_vec[CSEL_CH_PLL] = ref_code;
  assign sel_vec[CSEL_CH_DSP] = dsp_divider_source_q;
  assign sel_vec[CSEL_CH_DAC] = dac_divider_source_q;
  assign sel_vec[CSEL_CH_OSR] = oversample_divider_source_q;
  assign sel_vec[CSEL_CH_NCP] = charge_pump_divider_source_q;

  // one runt-free switch per channel
  for (genvar ch = 0; ch < CSEL_NCH; ch++) begin : g_ch
    csel_switch u_sw (
      .mclk(mclk),
      .reset(reset),
      .src(src_vec[ch]),
      .sel(sel_vec[ch]),
      .clk_out(out_vec[ch])
    ); // [RQ14]
  end

  // outputs are the registered switch levels
  assign clk_sel.pll_ref = out_vec[CSEL_CH_PLL];
  assign clk_sel.dsp_div = out_vec[CSEL_CH_DSP];
  assign clk_sel.dac_div = out_vec[CSEL_CH_DAC];
  assign clk_sel.osr_div = out_vec[CSEL_CH_OSR];
  assign clk_sel.ncp_div = out_vec[CSEL_CH_NCP];
endmodule

// *** tb/csel_checker.sv ***
// checker: port properties of the clock source selection block
`timescale 1ns/1ps
module csel_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // candidate and selected clocks
  input wire csel_pkg::csel_src_t clk_src,
  input wire csel_pkg::csel_clk_out_t clk_sel
);
  import csel_pkg::*;
  logic [2:0] dsp_q; // shadow of the dsp source field
  logic [2:0] cnt_q; // quiet samples since that field changed
  wire [2:0] dsp_d = (reg_wr && reg_addr == CSEL_OFS_PLL_DSP) ? reg_wdata[2:0] : dsp_q;
  wire quiet = clk_src == '0; // every candidate low
  wire [2:0] cnt_d = (dsp_d != dsp_q) ? 3'h0 : (quiet && cnt_q < 3'h4) ? cnt_q + 3'h1 : cnt_q;
  wire mapped = reg_addr >= CSEL_OFS_PLL_DSP && reg_addr <= CSEL_OFS_ROUTE_C;
  wire [7:0] mask = (reg_addr == CSEL_OFS_NCP || reg_addr == CSEL_OFS_ROUTE_C) ? 8'h07 : 8'h77;
  // shadow field and quiet counter
  always_ff @(posedge mclk) begin
    dsp_q <= reset ? CSEL_FIELD_RST : dsp_d;
    cnt_q <= reset ? 3'h0 : cnt_d;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  AST_RST_CLEAR: assert property ($fell(reset) |-> clk_sel == '0 && reg_rdata == 8'h00)
    else $error("outputs not cleared by reset");
  AST_RSV_ZERO: assert property (reg_rd |=> !reg_rdata[7] && !reg_rdata[3])
    else $error("reserved bit read as one");
  AST_UNMAPPED: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
    else $error("unmapped offset read nonzero");
  AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  AST_WR_RD: assert property (reg_wr && mapped ##1 reg_rd && !reg_wr
    && reg_addr == $past(reg_addr) |=> reg_rdata == ($past(reg_wdata, 2) & $past(mask, 2)))
    else $error("read back differs from write");
  AST_MUTE_HOLD: assert property (dsp_q == 3'h7 && $past(dsp_q) == 3'h7
    && $past(dsp_q, 2) == 3'h7 && !clk_sel.dsp_div |=> !clk_sel.dsp_div)
    else $error("muted dsp clock moved");
  AST_FOLLOW: assert property (cnt_q == 3'h4 && dsp_q == 3'h1
    |=> clk_sel.dsp_div == $past(clk_src.pll_clk))
    else $error("dsp clock does not follow pll");
  AST_SRC_ZERO: assert property ($past(quiet) && $past(quiet, 2) |-> clk_sel == '0)
    else $error("clock output high with all sources low");
endmodule
bind csel_top csel_checker u_chk (.mclk, .reset, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
  .reg_rdata, .clk_src, .clk_sel);

// *** tb/test_clock_source_select.sv ***
// self-checking bench for the clock source selection block
`timescale 1ns/1ps
module test_clock_source_select;
  import csel_pkg::*;
  // row: registers 0x0d..0x12, auto inputs, sources, expected clocks
  typedef struct packed {logic [47:0] regs; logic [5:0] am; logic [4:0] src, exp;} csel_row_t;
  localparam csel_row_t ROWS [19] = '{
    {48'h000000000000, 6'h00, 5'h04, 5'h1f},
    {48'h112403000000, 6'h00, 5'h02, 5'h10},
    {48'h112403000000, 6'h00, 5'h08, 5'h05},
    {48'h112403000000, 6'h00, 5'h14, 5'h0a},
    {48'h243502000000, 6'h00, 5'h0a, 5'h1a},
    {48'h355606555505, 6'h00, 5'h01, 5'h1f},
    {48'h355606443306, 6'h00, 5'h01, 5'h00},
    {48'h477707000000, 6'h00, 5'h1f, 5'h00},
    {48'h000101000000, 6'h24, 5'h02, 5'h10},
    {48'h000101000000, 6'h06, 5'h08, 5'h0f},
    {48'h000101000000, 6'h01, 5'h10, 5'h0f},
    {48'h000101000005, 6'h2c, 5'h01, 5'h10},
    {48'h000101000000, 6'h34, 5'h1f, 5'h0f},
    {48'h031204000000, 6'h00, 5'h10, 5'h06},
    {48'h031204000000, 6'h00, 5'h04, 5'h19},
    {48'h064305000000, 6'h00, 5'h0a, 5'h07},
    {48'h064305000000, 6'h00, 5'h1f, 5'h17},
    {48'h006000000000, 6'h00, 5'h1f, 5'h18},
    {48'h000000000000, 6'h03, 5'h08, 5'h0f}
  };
  logic mclk, reset, reg_wr, reg_rd; // clock, reset, strobes
  logic [7:0] reg_addr, reg_wdata, reg_rdata; // register port
  logic [5:0] am; // mode, pll ref code, use oscillator, use pll
  wire auto_clock_mode = am[5];
  wire [2:0] auto_pll_ref_select = am[4:2];
  wire auto_master_use_oscillator = am[1];
  wire auto_master_use_pll = am[0];
  csel_src_t clk_src; // candidate clocks
  csel_clk_out_t clk_sel; // selected clocks
  int failures; // mismatches
  int samples_checked; // comparisons
  csel_top u_dut (.mclk, .reset, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .auto_clock_mode, .auto_pll_ref_select, .auto_master_use_oscillator, .auto_master_use_pll,
    .clk_src, .clk_sel);
  // 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // compare register data
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // compare selected clocks
  task automatic chk5(input logic [4:0] got, input logic [4:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one read cycle, data checked the cycle after
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    chk8(reg_rdata, e);
  endtask
  // write then read back at once, readable bits given by m
  task automatic wrd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    rd(a, d & m);
  endtask
  // reset for five cycles, then all fields read zero
  task automatic do_reset();
    reset = 1'b1;
    repeat (5) @(negedge mclk);
    chk5(clk_sel, 5'h00);
    chk8(reg_rdata, 8'h00);
    reset = 1'b0;
    for (int k = 0; k < 6; k++) rd(8'h0d + 8'(k), 8'h00);
  endtask
  // counts, verdict and stop
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    {reset, reg_wr, reg_rd, reg_addr, reg_wdata, am} = {3'b100, 22'h0};
    clk_src = '0;
    failures = 0;
    samples_checked = 0;
    do_reset();
    // table of selections
    foreach (ROWS[i]) begin
      @(negedge mclk);
      clk_src = '0; // all low so any switch whose code changes parks at once
      am = ROWS[i].am;
      for (int k = 0; k < 6; k++) begin
        wrd(8'h0d + 8'(k), ROWS[i].regs[47 - 8 * k -: 8], 8'hff);
      end
      repeat (8) @(negedge mclk);
      clk_src = ROWS[i].src;
      repeat (4) @(negedge mclk);
      chk5(clk_sel, ROWS[i].exp);
    end
    // reserved bits and unmapped offsets
    for (int k = 0; k < 6; k++) begin
      wrd(8'h0d + 8'(k), 8'hff, (k == 2 || k == 5) ? 8'h07 : 8'h77);
    end
    wrd(8'h13, 8'hff, 8'h00);
    rd(8'h0c, 8'h00);
    // dsp divider moves from pll to oscillator with no runt
    clk_src = '0;
    wrd(8'h0d, 8'h01, 8'hff);
    repeat (6) @(negedge mclk);
    clk_src = 5'h18;
    repeat (3) @(negedge mclk);
    chk5(clk_sel & 5'h08, 5'h08);
    wrd(8'h0d, 8'h02, 8'hff);
    repeat (4) @(negedge mclk);
    chk5(clk_sel & 5'h08, 5'h08);
    clk_src = 5'h08;
    repeat (4) @(negedge mclk);
    chk5(clk_sel & 5'h08, 5'h00);
    clk_src = '0;
    @(negedge mclk);
    clk_src = 5'h08;
    repeat (3) @(negedge mclk);
    chk5(clk_sel & 5'h08, 5'h08);
    // reset in mid-run with every source high
    clk_src = 5'h1f;
    do_reset();
    end_sim();
  end
endmodule
